/* File: logic/ilpc_pkg.sv */
`default_nettype none
package ilpc_pkg;
    // Register word indices; byte address is four times the index
    localparam logic [9:0] IDX_PORT_A_DATA  = 10'h0C0;
    localparam logic [9:0] IDX_PORT_B_DATA  = 10'h0C1;
    localparam logic [9:0] IDX_PORT_C_DATA  = 10'h0C2;
    localparam logic [9:0] IDX_PORT_A_OPT   = 10'h0C4;
    localparam logic [9:0] IDX_PORT_B_OPT   = 10'h0C5;
    localparam logic [9:0] IDX_PORT_C_OPT   = 10'h0C6;
    localparam logic [9:0] IDX_INT_OPTION   = 10'h0C8;
    localparam logic [9:0] IDX_CONV_CTRL    = 10'h0D1;
    localparam logic [9:0] IDX_TIMER_CTRL   = 10'h0D4;
    localparam logic [9:0] IDX_RELOAD_CTRL  = 10'h0D5;
    localparam logic [9:0] IDX_EVT_STATUS   = 10'h0E0;
    localparam logic [9:0] IDX_EVT_MASK     = 10'h0E1;
    localparam logic [9:0] IDX_LP_STATUS    = 10'h0E2;
    localparam logic [9:0] IDX_CLK_SEL      = 10'h0E3;
    // Field positions
    localparam int BIT_GLOBAL_EN   = 4;
    localparam int BIT_TIMER_EN    = 0;
    localparam int BIT_CONV_EN     = 0;
    localparam int BIT_RELOAD_OVF  = 0;
    localparam int BIT_COMPARE     = 1;
    localparam int BIT_EDGE        = 2;
    localparam int EVT_WAKE        = 0;
    localparam int EVT_REFUSED     = 1;
    localparam int EVT_STOP_AS_WT  = 2;
    // Reset values
    localparam logic [7:0] RST_REG   = 8'h00;
    localparam logic [2:0] RST_EVT   = 3'h0;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Core execution modes
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_IRQ    = 2'h1;
    localparam logic [1:0] MODE_NMI    = 2'h2;
    // Oscillator stabilisation hold, in clock cycles
    localparam int STAB_CYCLES = 2048;
    localparam int STAB_W      = 12;
    typedef enum logic [3:0] {
        ST_RUN  = 4'h1,
        ST_WAIT = 4'h2,
        ST_STOP = 4'h4,
        ST_STAB = 4'h8
    } ilpc_state_e;
endpackage : ilpc_pkg
`default_nettype wire

/* File: logic/ilpc_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// (R1) Port pins gated per pin; ports A and B request vector 1, port C vector 2.
// (R2) Timer zero and converter end events go to vector 4, each enabled separately.
// (R3) Reload overflow, compare and input edge OR onto vector 3, each enabled.
// (R4) Global enable masks every source except the non-maskable one.
// (R5) WAIT halts the core at once; clock and peripherals keep running.
// (R6) Interrupt ending WAIT resumes the core with no stabilisation delay.
// (R7) Reset during WAIT or STOP abandons it and runs the normal reset.
// (R8) STOP halts the core and stops the oscillator until interrupt or reset.
// (R9) Interrupt ending STOP holds the first instruction for oscillator stabilisation.
// (R10) With the watchdog active, STOP acts exactly as WAIT.
// (R11) Sleep from main routine: waking service routine runs first.
// (R12) Sleep inside non-maskable routine: continue at next instruction, stay there.
// (R13) Sleep in maskable routine, maskable wake: continue at next instruction.
// (R14) Sleep in maskable routine, non-maskable wake: non-maskable routine runs first.
// (R15) Global enable low: no interrupt wakes, the non-maskable one included.
// (R16) WAIT or STOP refused while an enabled request is pending.
// (R17) Waking leaves the oscillator source selection unchanged.
// (R18) Global enable is bit 4 of the write-only interrupt option register.
// (R19) Stabilisation hold is a down-counter of parameter length on the restarted clock.
module ilpc_top #(
    parameter int STAB_CYCLES = ilpc_pkg::STAB_CYCLES
) (
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_N_I,
    input  wire logic [11:0] S_AXI_AWADDR_I,
    input  wire logic        S_AXI_AWVALID_I,
    output logic             S_AXI_AWREADY_O,
    input  wire logic [31:0] S_AXI_WDATA_I,
    input  wire logic [3:0]  S_AXI_WSTRB_I,
    input  wire logic        S_AXI_WVALID_I,
    output logic             S_AXI_WREADY_O,
    output logic [1:0]       S_AXI_BRESP_O,
    output logic             S_AXI_BVALID_O,
    input  wire logic        S_AXI_BREADY_I,
    input  wire logic [11:0] S_AXI_ARADDR_I,
    input  wire logic        S_AXI_ARVALID_I,
    output logic             S_AXI_ARREADY_O,
    output logic [31:0]      S_AXI_RDATA_O,
    output logic [1:0]       S_AXI_RRESP_O,
    output logic             S_AXI_RVALID_O,
    input  wire logic        S_AXI_RREADY_I,
    input  wire logic [7:0]  PORT_A_PIN_I,
    input  wire logic [7:0]  PORT_B_PIN_I,
    input  wire logic [7:0]  PORT_C_PIN_I,
    input  wire logic        TIMER_ZERO_FLAG_I,
    input  wire logic        CONV_END_FLAG_I,
    input  wire logic        RELOAD_OVERFLOW_FLAG_I,
    input  wire logic        COMPARE_MATCH_FLAG_I,
    input  wire logic        INPUT_EDGE_FLAG_I,
    input  wire logic        NMI_REQ_I,
    input  wire logic        WAIT_EXEC_I,
    input  wire logic        STOP_EXEC_I,
    input  wire logic [1:0]  CORE_MODE_I,
    input  wire logic        WDG_ACTIVE_I,
    output logic [4:0]       VECTOR_REQ_O,
    output logic             CORE_HALT_O,
    output logic             OSC_STOP_O,
    output logic             RESUME_O,
    output logic             RESUME_SERVICE_O,
    output logic             OSC_SEL_O,
    output logic             IRQ_O
);
    // Register file
    logic [7:0] port_a_data_r, port_b_data_r, port_c_data_r;
    logic [7:0] port_a_opt_r,  port_b_opt_r,  port_c_opt_r;
    logic [7:0] interrupt_option_control_r;
    logic [7:0] converter_control_r, timer_status_control_r, reload_timer_mode_control_r;
    logic [2:0] evt_sts_r, evt_mask_r, evt_set;
    logic       osc_sel_r;
    // Bus slave
    logic        aw_got_r, w_got_r;
    logic [9:0]  aw_idx_r;
    logic [7:0]  wdata_r;
    logic        wlane_r;
    logic        bvalid_r, rvalid_r;
    logic [1:0]  bresp_r, rresp_r;
    logic [31:0] rdata_r;
    // Sequencer
    localparam int STAB_W_L = ilpc_pkg::STAB_W;

    ilpc_pkg::ilpc_state_e state_r, state_nxt;
    logic [STAB_W_L-1:0]   stab_cnt_r;
    logic [1:0]            mode_r;
    logic                  resume_r, svc_r;

    function automatic logic idx_mapped(input logic [9:0] idx);
        idx_mapped = (idx == ilpc_pkg::IDX_PORT_A_DATA) || (idx == ilpc_pkg::IDX_PORT_B_DATA)
                  || (idx == ilpc_pkg::IDX_PORT_C_DATA) || (idx == ilpc_pkg::IDX_PORT_A_OPT)
                  || (idx == ilpc_pkg::IDX_PORT_B_OPT)  || (idx == ilpc_pkg::IDX_PORT_C_OPT)
                  || (idx == ilpc_pkg::IDX_INT_OPTION)  || (idx == ilpc_pkg::IDX_CONV_CTRL)
                  || (idx == ilpc_pkg::IDX_TIMER_CTRL)  || (idx == ilpc_pkg::IDX_RELOAD_CTRL)
                  || (idx == ilpc_pkg::IDX_EVT_STATUS)  || (idx == ilpc_pkg::IDX_EVT_MASK)
                  || (idx == ilpc_pkg::IDX_LP_STATUS)   || (idx == ilpc_pkg::IDX_CLK_SEL);
    endfunction : idx_mapped

    // Interrupt routing
    wire        global_irq_enable = interrupt_option_control_r[ilpc_pkg::BIT_GLOBAL_EN]; // R18
    wire [7:0]  pin_en_a = port_a_opt_r & ~port_a_data_r;
    wire [7:0]  pin_en_b = port_b_opt_r & ~port_b_data_r;
    wire [7:0]  pin_en_c = port_c_opt_r & ~port_c_data_r;
    wire        src_v1 = |(~PORT_A_PIN_I & pin_en_a) | |(~PORT_B_PIN_I & pin_en_b); // R1
    wire        src_v2 = |(~PORT_C_PIN_I & pin_en_c); // R1
    wire        src_v3 = (RELOAD_OVERFLOW_FLAG_I & reload_timer_mode_control_r[ilpc_pkg::BIT_RELOAD_OVF])
                       | (COMPARE_MATCH_FLAG_I & reload_timer_mode_control_r[ilpc_pkg::BIT_COMPARE])
                       | (INPUT_EDGE_FLAG_I & reload_timer_mode_control_r[ilpc_pkg::BIT_EDGE]); // R3
    wire        src_v4 = (TIMER_ZERO_FLAG_I & timer_status_control_r[ilpc_pkg::BIT_TIMER_EN])
                       | (CONV_END_FLAG_I & converter_control_r[ilpc_pkg::BIT_CONV_EN]); // R2
    wire [3:0]  mask_req = {4{global_irq_enable}} & {src_v4, src_v3, src_v2, src_v1}; // R4
    wire        any_mask = |mask_req;
    wire        wake_req = global_irq_enable & (any_mask | NMI_REQ_I); // R15
    wire        in_nmi   = (CORE_MODE_I == ilpc_pkg::MODE_NMI);
    wire        sleeping = (state_r != ilpc_pkg::ST_RUN);

    assign VECTOR_REQ_O = {mask_req & {4{~in_nmi & ~sleeping}}, NMI_REQ_I & ~sleeping}; // R12
    assign CORE_HALT_O  = sleeping; // R5
    assign OSC_STOP_O   = (state_r == ilpc_pkg::ST_STOP); // R8
    assign OSC_SEL_O    = osc_sel_r; // R17
    assign RESUME_O     = resume_r;
    assign RESUME_SERVICE_O = svc_r;

    // Low-power sequencer
    wire lp_exec    = WAIT_EXEC_I | STOP_EXEC_I;
    wire refuse     = lp_exec & wake_req; // R16
    wire stop_block = STOP_EXEC_I & WDG_ACTIVE_I; // R10
    wire stab_done  = (stab_cnt_r == '0);
    wire wake_svc   = (mode_r == ilpc_pkg::MODE_NORMAL) // R11
                    | ((mode_r == ilpc_pkg::MODE_IRQ) & ~any_mask & NMI_REQ_I); // R14
    wire leave_now  = (state_r == ilpc_pkg::ST_WAIT) & wake_req; // R6
    wire leave_stab = (state_r == ilpc_pkg::ST_STAB) & stab_done; // R9

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ilpc_pkg::ST_RUN:
            begin
                if (lp_exec && !refuse)
                begin
                    state_nxt = (STOP_EXEC_I && !stop_block) ? ilpc_pkg::ST_STOP : ilpc_pkg::ST_WAIT; // R10
                end
            end
            ilpc_pkg::ST_WAIT:
            begin
                if (wake_req)
                begin
                    state_nxt = ilpc_pkg::ST_RUN; // R6
                end
            end
            ilpc_pkg::ST_STOP:
            begin
                if (wake_req)
                begin
                    state_nxt = ilpc_pkg::ST_STAB; // R9
                end
            end
            ilpc_pkg::ST_STAB:
            begin
                if (stab_done)
                begin
                    state_nxt = ilpc_pkg::ST_RUN;
                end
            end
            default:
            begin
                state_nxt = ilpc_pkg::ST_RUN;
            end
        endcase
    end

    wire stab_load = (state_r == ilpc_pkg::ST_STOP) & wake_req;
    wire [STAB_W_L-1:0] stab_init = STAB_W_L'(STAB_CYCLES - 1);

    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            state_r    <= ilpc_pkg::ST_RUN; // R7
            stab_cnt_r <= '0;
            mode_r     <= ilpc_pkg::MODE_NORMAL;
            resume_r   <= 1'b0;
            svc_r      <= 1'b0;
        end
        else
        begin
            state_r  <= state_nxt;
            resume_r <= leave_now | leave_stab;
            if (stab_load)
                stab_cnt_r <= stab_init; // R19
            else if (!stab_done)
                stab_cnt_r <= stab_cnt_r - 1'b1; // R19
            if (state_r == ilpc_pkg::ST_RUN && lp_exec && !refuse)
                mode_r <= CORE_MODE_I;
            if (leave_now || stab_load)
                svc_r <= wake_svc; // R13
        end
    end

    // Event status, set wins over clear
    assign evt_set[ilpc_pkg::EVT_WAKE]       = leave_now | stab_load;
    assign evt_set[ilpc_pkg::EVT_REFUSED]    = (state_r == ilpc_pkg::ST_RUN) & refuse;
    assign evt_set[ilpc_pkg::EVT_STOP_AS_WT] = (state_r == ilpc_pkg::ST_RUN) & stop_block & ~refuse;
    assign IRQ_O = |(evt_sts_r & evt_mask_r);

    // AXI4-Lite write path
    wire       aw_take = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
    wire       w_take  = S_AXI_WVALID_I & S_AXI_WREADY_O;
    wire       wr_go   = aw_got_r & w_got_r;
    wire       wr_ok   = idx_mapped(aw_idx_r);
    wire       wr_en   = wr_go & wr_ok & wlane_r;
    assign S_AXI_AWREADY_O = ~aw_got_r & ~bvalid_r;
    assign S_AXI_WREADY_O  = ~w_got_r & ~bvalid_r;
    assign S_AXI_BVALID_O  = bvalid_r;
    assign S_AXI_BRESP_O   = bresp_r;
    wire sts_clr_hit = wr_en & (aw_idx_r == ilpc_pkg::IDX_EVT_STATUS);
    wire [2:0] sts_clr = sts_clr_hit ? wdata_r[2:0] : 3'h0;

    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            aw_idx_r <= '0;
            wdata_r  <= ilpc_pkg::RST_REG;
            wlane_r  <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r  <= ilpc_pkg::RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_got_r <= 1'b1;
                aw_idx_r <= S_AXI_AWADDR_I[11:2];
            end
            if (w_take)
            begin
                w_got_r <= 1'b1;
                wdata_r <= S_AXI_WDATA_I[7:0];
                wlane_r <= S_AXI_WSTRB_I[0];
            end
            if (wr_go)
            begin
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r  <= wr_ok ? ilpc_pkg::RESP_OKAY : ilpc_pkg::RESP_SLVERR;
            end
            else if (bvalid_r && S_AXI_BREADY_I)
                bvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            port_a_data_r <= ilpc_pkg::RST_REG;
            port_b_data_r <= ilpc_pkg::RST_REG;
            port_c_data_r <= ilpc_pkg::RST_REG;
            port_a_opt_r  <= ilpc_pkg::RST_REG;
            port_b_opt_r  <= ilpc_pkg::RST_REG;
            port_c_opt_r  <= ilpc_pkg::RST_REG;
            interrupt_option_control_r  <= ilpc_pkg::RST_REG;
            converter_control_r         <= ilpc_pkg::RST_REG;
            timer_status_control_r      <= ilpc_pkg::RST_REG;
            reload_timer_mode_control_r <= ilpc_pkg::RST_REG;
            evt_sts_r  <= ilpc_pkg::RST_EVT;
            evt_mask_r <= ilpc_pkg::RST_EVT;
            osc_sel_r  <= 1'b0;
        end
        else
        begin
            evt_sts_r <= (evt_sts_r & ~sts_clr) | evt_set;
            if (wr_en)
            begin
                case (aw_idx_r)
                    ilpc_pkg::IDX_PORT_A_DATA: port_a_data_r <= wdata_r;
                    ilpc_pkg::IDX_PORT_B_DATA: port_b_data_r <= wdata_r;
                    ilpc_pkg::IDX_PORT_C_DATA: port_c_data_r <= wdata_r;
                    ilpc_pkg::IDX_PORT_A_OPT:  port_a_opt_r  <= wdata_r;
                    ilpc_pkg::IDX_PORT_B_OPT:  port_b_opt_r  <= wdata_r;
                    ilpc_pkg::IDX_PORT_C_OPT:  port_c_opt_r  <= wdata_r;
                    ilpc_pkg::IDX_INT_OPTION:  interrupt_option_control_r  <= wdata_r; // R18
                    ilpc_pkg::IDX_CONV_CTRL:   converter_control_r         <= wdata_r;
                    ilpc_pkg::IDX_TIMER_CTRL:  timer_status_control_r      <= wdata_r;
                    ilpc_pkg::IDX_RELOAD_CTRL: reload_timer_mode_control_r <= wdata_r;
                    ilpc_pkg::IDX_EVT_MASK:    evt_mask_r <= wdata_r[2:0];
                    ilpc_pkg::IDX_CLK_SEL:     osc_sel_r  <= wdata_r[0];
                    default:                   osc_sel_r  <= osc_sel_r;
                endcase
            end
        end
    end

    // AXI4-Lite read path
    wire       ar_take = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
    wire [9:0] ar_idx  = S_AXI_ARADDR_I[11:2];
    logic [7:0] rd_val;
    assign S_AXI_ARREADY_O = ~rvalid_r;
    assign S_AXI_RVALID_O  = rvalid_r;
    assign S_AXI_RDATA_O   = rdata_r;
    assign S_AXI_RRESP_O   = rresp_r;

    always_comb
    begin
        case (ar_idx)
            ilpc_pkg::IDX_PORT_A_DATA: rd_val = port_a_data_r;
            ilpc_pkg::IDX_PORT_B_DATA: rd_val = port_b_data_r;
            ilpc_pkg::IDX_PORT_C_DATA: rd_val = port_c_data_r;
            ilpc_pkg::IDX_PORT_A_OPT:  rd_val = port_a_opt_r;
            ilpc_pkg::IDX_PORT_B_OPT:  rd_val = port_b_opt_r;
            ilpc_pkg::IDX_PORT_C_OPT:  rd_val = port_c_opt_r;
            ilpc_pkg::IDX_CONV_CTRL:   rd_val = converter_control_r;
            ilpc_pkg::IDX_TIMER_CTRL:  rd_val = timer_status_control_r;
            ilpc_pkg::IDX_RELOAD_CTRL: rd_val = reload_timer_mode_control_r;
            ilpc_pkg::IDX_EVT_STATUS:  rd_val = {5'h00, evt_sts_r};
            ilpc_pkg::IDX_EVT_MASK:    rd_val = {5'h00, evt_mask_r};
            ilpc_pkg::IDX_LP_STATUS:   rd_val = {2'h0, mode_r, state_r};
            ilpc_pkg::IDX_CLK_SEL:     rd_val = {7'h00, osc_sel_r};
            default:                   rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= ilpc_pkg::RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_r <= 1'b1;
            rdata_r  <= {24'h00_0000, rd_val};
            rresp_r  <= idx_mapped(ar_idx) ? ilpc_pkg::RESP_OKAY : ilpc_pkg::RESP_SLVERR;
        end
        else if (rvalid_r && S_AXI_RREADY_I)
            rvalid_r <= 1'b0;
    end

    // Checks
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);

    chk_wait_fast_exit: assert property ( // R6
        state_r == ilpc_pkg::ST_WAIT && wake_req |=> state_r == ilpc_pkg::ST_RUN && RESUME_O)
        else $error("wait exit not immediate");
    chk_stop_hold: assert property ( // R9
        state_r == ilpc_pkg::ST_STOP && wake_req |=> state_r == ilpc_pkg::ST_STAB && stab_cnt_r == stab_init)
        else $error("stop exit skipped stabilisation");
    chk_stab_release: assert property ( // R19
        RESUME_O && $past(state_r) == ilpc_pkg::ST_STAB |-> $past(stab_cnt_r) == '0)
        else $error("released before counter expired");
    chk_stop_as_wait: assert property ( // R10
        state_r == ilpc_pkg::ST_RUN && STOP_EXEC_I && WDG_ACTIVE_I && !wake_req
        |=> state_r == ilpc_pkg::ST_WAIT && !OSC_STOP_O)
        else $error("stop not blocked by watchdog");
    chk_refuse_pending: assert property ( // R16
        state_r == ilpc_pkg::ST_RUN && lp_exec && wake_req |=> !CORE_HALT_O)
        else $error("low power entered with pending request");
    chk_gen_no_wake: assert property ( // R15
        CORE_HALT_O && !global_irq_enable && !stab_load && !leave_stab |=> CORE_HALT_O)
        else $error("wake with global enable low");
    chk_gen_masks: assert property ( // R4
        !global_irq_enable |-> VECTOR_REQ_O[4:1] == 4'h0)
        else $error("maskable vector with global enable low");
    chk_osc_stopped: assert property ( // R8
        state_r == ilpc_pkg::ST_RUN && STOP_EXEC_I && !WDG_ACTIVE_I && !wake_req
        |=> OSC_STOP_O && CORE_HALT_O)
        else $error("oscillator not stopped");
    chk_osc_sel_kept: assert property ( // R17
        RESUME_O |-> $stable(OSC_SEL_O))
        else $error("wake changed oscillator selection");
    chk_nmi_continue: assert property ( // R12
        RESUME_O && mode_r == ilpc_pkg::MODE_NMI |-> !RESUME_SERVICE_O)
        else $error("service entered from nmi sleep");
    chk_main_service: assert property ( // R11
        RESUME_O && mode_r == ilpc_pkg::MODE_NORMAL |-> RESUME_SERVICE_O)
        else $error("main routine wake skipped service");
    chk_event_set: assert property ( // R16
        evt_set[ilpc_pkg::EVT_REFUSED] |=> evt_sts_r[ilpc_pkg::EVT_REFUSED])
        else $error("refused flag lost");

    cov_wait_wake:  cover property (state_r == ilpc_pkg::ST_WAIT ##1 RESUME_O);
    cov_stop_wake:  cover property (state_r == ilpc_pkg::ST_STAB ##1 RESUME_O);
    cov_refused:    cover property (evt_set[ilpc_pkg::EVT_REFUSED]);
    cov_stop_block: cover property (evt_set[ilpc_pkg::EVT_STOP_AS_WT]);
endmodule : ilpc_top
`default_nettype wire

/* File: bench/ilpc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Core sequencer: issues WAIT or STOP only while running
module ilpc_core_model (
    input  wire logic  clk_i,
    input  wire logic  halt_i,
    output logic       wait_exec_o,
    output logic       stop_exec_o,
    output logic [1:0] core_mode_o
);
    initial
    begin
        wait_exec_o = 1'b0;
        stop_exec_o = 1'b0;
        core_mode_o = ilpc_pkg::MODE_NORMAL;
    end
    // One-cycle execute pulse, mode held afterwards
    task automatic exec(input logic is_stop, input logic [1:0] mode);
        while (halt_i !== 1'b0)
            @(posedge clk_i);
        core_mode_o <= mode;
        wait_exec_o <= ~is_stop;
        stop_exec_o <= is_stop;
        @(posedge clk_i);
        wait_exec_o <= 1'b0;
        stop_exec_o <= 1'b0;
    endtask : exec
endmodule : ilpc_core_model
`default_nettype wire

/* File: bench/irq_routing_and_low_power_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_routing_and_low_power_control_bench;
    localparam int STAB = 4;
    logic clk, awr, wr, bv, arr, rv, halt, oscs, res, ressv, osel, irq, wx, sx;
    logic rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, wdg = 1'b0;
    logic [11:0] awa = 12'h000, ara = 12'h000;
    logic [31:0] wd = 32'h0, rdata;
    logic [1:0]  bresp, rresp, mode;
    logic [8:0]  src = 9'h000;
    logic [4:0]  vec;
    int          errors = 0, n_compared = 0;
    ilpc_top #(.STAB_CYCLES(STAB)) dut_u (
        .REF_CLK_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
        .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv),
        .S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
        .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata),
        .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry),
        .PORT_A_PIN_I({7'h7F, ~src[0]}), .PORT_B_PIN_I({7'h7F, ~src[1]}), .PORT_C_PIN_I({7'h7F, ~src[2]}),
        .TIMER_ZERO_FLAG_I(src[3]), .CONV_END_FLAG_I(src[4]), .RELOAD_OVERFLOW_FLAG_I(src[5]),
        .COMPARE_MATCH_FLAG_I(src[6]), .INPUT_EDGE_FLAG_I(src[7]), .NMI_REQ_I(src[8]),
        .WAIT_EXEC_I(wx), .STOP_EXEC_I(sx), .CORE_MODE_I(mode), .WDG_ACTIVE_I(wdg),
        .VECTOR_REQ_O(vec), .CORE_HALT_O(halt), .OSC_STOP_O(oscs), .RESUME_O(res),
        .RESUME_SERVICE_O(ressv), .OSC_SEL_O(osel), .IRQ_O(irq));
    ilpc_core_model mdl_u (.clk_i(clk), .halt_i(halt), .wait_exec_o(wx), .stop_exec_o(sx), .core_mode_o(mode));
    task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : cmp
    task automatic axi_wr(input logic [9:0] idx, input logic [7:0] d);
        @(posedge clk);
        awa <= {idx, 2'b00};
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (awr === 1'b1)
                awv <= 1'b0;
            if (wr === 1'b1)
                wv <= 1'b0;
            if (bv === 1'b1)
                break;
        end
        bry <= 1'b0;
        cmp(32'(bresp), 32'(ilpc_pkg::RESP_OKAY));
    endtask : axi_wr
    task automatic axi_rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        ara <= {idx, 2'b00};
        arv <= 1'b1;
        rry <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (arr === 1'b1)
                arv <= 1'b0;
            if (rv === 1'b1)
                break;
        end
        rry <= 1'b0;
        d = rdata;
        r = rresp;
    endtask : axi_rd
    // Sleep, raise source s, count edges until resume
    task automatic lp_wake(input logic stop, input logic [1:0] m, input int s, input int ecnt, input logic esv);
        int n;
        mdl_u.exec(stop, m);
        @(posedge clk);
        cmp(32'(halt), 32'h1);
        cmp(32'(oscs), 32'(stop & ~wdg));
        src <= 9'h001 << s;
        n = 0;
        while (res !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        cmp(n, ecnt);
        cmp(32'(ressv), 32'(esv));
        src <= 9'h000;
        @(posedge clk);
        cmp(32'(halt), 32'h0);
    endtask : lp_wake
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        axi_wr(ilpc_pkg::IDX_INT_OPTION, 8'h10);
        axi_rd(ilpc_pkg::IDX_INT_OPTION, d, r);
        cmp(d, 32'h0);
        axi_rd(10'h0FF, d, r);
        cmp(32'(r), 32'(ilpc_pkg::RESP_SLVERR));
        axi_wr(ilpc_pkg::IDX_TIMER_CTRL, 8'h01);
        axi_wr(ilpc_pkg::IDX_CONV_CTRL, 8'h01);
        axi_wr(ilpc_pkg::IDX_RELOAD_CTRL, 8'h07);
        axi_wr(ilpc_pkg::IDX_PORT_A_OPT, 8'h01);
        axi_wr(ilpc_pkg::IDX_PORT_B_OPT, 8'h01);
        axi_wr(ilpc_pkg::IDX_PORT_C_OPT, 8'h01);
        axi_wr(ilpc_pkg::IDX_EVT_MASK, 8'h07);
        axi_wr(ilpc_pkg::IDX_CLK_SEL, 8'h01);
        $display("test regs done");
    endtask : t_regs
    task automatic t_route;
        logic [4:0] ev [8] = '{5'h02, 5'h02, 5'h04, 5'h10, 5'h10, 5'h08, 5'h08, 5'h08};
        for (int i = 0; i < 8; i++)
        begin
            src <= 9'h001 << i;
            repeat (2) @(posedge clk);
            cmp(32'(vec), 32'(ev[i]));
        end
        axi_wr(ilpc_pkg::IDX_RELOAD_CTRL, 8'h06);
        axi_wr(ilpc_pkg::IDX_PORT_A_DATA, 8'h01);
        src <= 9'h021;
        repeat (2) @(posedge clk);
        cmp(32'(vec), 32'h00);
        axi_wr(ilpc_pkg::IDX_RELOAD_CTRL, 8'h07);
        axi_wr(ilpc_pkg::IDX_PORT_A_DATA, 8'h00);
        axi_wr(ilpc_pkg::IDX_INT_OPTION, 8'h00);
        src <= 9'h1FF;
        repeat (2) @(posedge clk);
        cmp(32'(vec), 32'h01);
        src <= 9'h000;
        axi_wr(ilpc_pkg::IDX_INT_OPTION, 8'h10);
        $display("test route done");
    endtask : t_route
    task automatic t_lp;
        lp_wake(1'b0, ilpc_pkg::MODE_NORMAL, 3, 2, 1'b1);
        lp_wake(1'b0, ilpc_pkg::MODE_NMI, 3, 2, 1'b0);
        lp_wake(1'b0, ilpc_pkg::MODE_IRQ, 2, 2, 1'b0);
        lp_wake(1'b1, ilpc_pkg::MODE_IRQ, 8, STAB + 2, 1'b1);
        cmp(32'(osel), 32'h1);
        $display("test low power done");
    endtask : t_lp
    task automatic t_events;
        logic [31:0] d;
        logic [1:0] r;
        axi_wr(ilpc_pkg::IDX_EVT_STATUS, 8'h07);
        cmp(32'(irq), 32'h0);
        src <= 9'h008;
        mdl_u.exec(1'b0, ilpc_pkg::MODE_NORMAL);
        @(posedge clk);
        cmp(32'(halt), 32'h0);
        src <= 9'h000;
        wdg <= 1'b1;
        lp_wake(1'b1, ilpc_pkg::MODE_NORMAL, 3, 2, 1'b1);
        wdg <= 1'b0;
        axi_rd(ilpc_pkg::IDX_EVT_STATUS, d, r);
        cmp(d, 32'h07);
        cmp(32'(irq), 32'h1);
        axi_wr(ilpc_pkg::IDX_EVT_STATUS, 8'h07);
        cmp(32'(irq), 32'h0);
        $display("test events done");
    endtask : t_events
    task automatic t_genoff;
        axi_wr(ilpc_pkg::IDX_INT_OPTION, 8'h00);
        mdl_u.exec(1'b1, ilpc_pkg::MODE_NORMAL);
        src <= 9'h108;
        repeat (10) @(posedge clk);
        cmp(32'(halt), 32'h1);
        cmp(32'(oscs), 32'h1);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        src <= 9'h000;
        @(posedge clk);
        cmp(32'({halt, oscs}), 32'h0);
        $display("test global off done");
    endtask : t_genoff
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #100000;
        errors++;
        end_of_test();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_route();
        t_lp();
        t_events();
        t_genoff();
        end_of_test();
    end
endmodule : irq_routing_and_low_power_control_bench
`default_nettype wire
